// ### hw/mac_filter_pkg.sv
// Purpose: constants and types for the station address and hash filter
// Assumes: apb with 32-bit data, byte address = 4 * register index
// Notes: offsets are register indexes
package mac_filter_pkg;
    localparam logic [3:0] IDX_STATION_ADDRESS_HIGH = 4'h2;
    localparam logic [3:0] IDX_STATION_ADDRESS_LOW = 4'h3;
    localparam logic [3:0] IDX_GROUP_HASH_UPPER = 4'h4;
    localparam logic [3:0] IDX_GROUP_HASH_LOWER = 4'h5;
    localparam logic [3:0] IDX_FILTER_CONTROL = 4'h9;
    localparam logic [3:0] IDX_FILTER_STATUS = 4'hA;
    localparam logic [31:0] RST_STATION_ADDRESS_HIGH = 32'h0000FFFF;
    localparam logic [31:0] RST_STATION_ADDRESS_LOW = 32'h0FFFFFFF;
    localparam logic [31:0] RST_GROUP_HASH = 32'h00000000;
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
    localparam int CTRL_ACCEPT_ALL_BIT = 0;
    localparam int STAT_LOADED_BIT = 0;
    localparam int STAT_INIT_DONE_BIT = 1;
    localparam logic [3:0] ROM_FIRST_ADDR_BYTE = 4'h1;
    localparam logic [3:0] ROM_LAST_LOW_BYTE = 4'h4;
    localparam logic [3:0] ROM_LAST_ADDR_BYTE = 4'h6;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;

    typedef struct packed {
        logic valid;
        logic [47:0] dest;
    } frame_req_type;

    typedef struct packed {
        logic valid;
        logic [3:0] addr;
        logic [7:0] data;
    } rom_byte_type;
endpackage

// ### hw/mac_station_addr_hash_filter.sv
// Purpose: station address and multicast hash filter registers over apb
// Assumes: loader bytes and frame requests come from logic on CLOCK_I
// Notes: one decision per frame request, answer two cycles later
//
// Summary of operation
// - high register holds address bits 15:0
// - rom bytes 0x05, 0x06 load high register
// - low register holds address bits 47:16
// - rom bytes 0x01..0x04 fill low ascending
// - load only when programmed rom present
// - low bits 7:0 first byte on wire
// - leftmost address byte is sent first
// - six-bit index selects one of 64
// - index top bit picks upper or lower
// - zero index is lower bit 0
// - selected bit one accepts, zero rejects
// - accept-all bit passes every group frame
// - upper register holds table bits 63:32
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module mac_station_addr_hash_filter
    import mac_filter_pkg::*;
(
    // clock and reset
    input wire logic CLOCK_I,
    input wire logic SYS_RST_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // power-on loader
    input wire logic ROM_PROGRAMMED_I,
    input wire logic ROM_BYTE_VALID_I,
    input wire logic [3:0] ROM_BYTE_ADDR_I,
    input wire logic [7:0] ROM_BYTE_DATA_I,
    input wire logic INIT_DONE_I,
    // frame filter
    input wire logic FRAME_VALID_I,
    input wire logic [47:0] FRAME_DEST_I,
    output logic FILTER_VALID_O,
    output logic FILTER_ACCEPT_O,
    output logic [47:0] STATION_ADDRESS_O
);
    apb_req_type req;
    frame_req_type frm;
    rom_byte_type rom;
    logic [31:0] station_address_high;
    logic [31:0] station_address_low;
    logic [31:0] group_hash_upper;
    logic [31:0] group_hash_lower;
    logic accept_every_group_frame;
    logic loaded;
    logic init_done;
    logic access;
    logic [9:0] word_idx;
    logic idx_ok;
    logic [5:0] hash_index;
    logic frame_group;
    logic stage_valid;
    logic stage_group;
    logic [5:0] stage_index;
    logic [31:0] next_prdata;
    logic [31:0] dest_crc;
    logic [63:0] hash_table;

    assign req = '{PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I};
    assign frm = '{FRAME_VALID_I, FRAME_DEST_I};
    assign rom = '{ROM_BYTE_VALID_I, ROM_BYTE_ADDR_I, ROM_BYTE_DATA_I};
    assign access = req.psel && req.penable && PREADY_O;
    assign word_idx = req.paddr[11:2];
    assign idx_ok = (word_idx[9:4] == 6'h00) && (req.paddr[1:0] == 2'h0);

    // crc-32 over the six bytes in wire order, lsb of each byte first
    function automatic logic [31:0] crc_dest(input logic [47:0] a);
        logic [31:0] c;
        logic fb;
        c = CRC_INIT;
        for (int b = 0; b < 6; b++) begin
            for (int i = 0; i < 8; i++) begin
                // byte 0 is the leftmost (msb) byte of the address
                fb = c[31] ^ a[47 - 8 * b - 7 + i];
                c = {c[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h00000000);
            end
        end
        return c;
    endfunction

    function automatic logic reg_hit(input logic [3:0] idx);
        return idx_ok && (word_idx[3:0] == idx);
    endfunction

    assign dest_crc = crc_dest(frm.dest);
    assign hash_index = dest_crc[31:26];
    // whole table in index order, upper register on top
    assign hash_table = {group_hash_upper, group_hash_lower};
    // group bit is lsb of first byte on the wire
    assign frame_group = frm.dest[40];

    // apb answers with zero wait states; unmapped addresses flag pslverr
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            PREADY_O <= 1'b0;
        end else begin
            PREADY_O <= req.psel && !req.penable;
        end
    end

    always_comb begin
        next_prdata = 32'h00000000;
        case (1'b1)
            reg_hit(IDX_STATION_ADDRESS_HIGH): begin
                next_prdata = {16'h0000, station_address_high[15:0]};
            end
            reg_hit(IDX_STATION_ADDRESS_LOW): begin
                next_prdata = station_address_low;
            end
            reg_hit(IDX_GROUP_HASH_UPPER): next_prdata = group_hash_upper;
            reg_hit(IDX_GROUP_HASH_LOWER): next_prdata = group_hash_lower;
            reg_hit(IDX_FILTER_CONTROL): begin
                next_prdata[CTRL_ACCEPT_ALL_BIT] = accept_every_group_frame;
            end
            reg_hit(IDX_FILTER_STATUS): begin
                next_prdata[STAT_LOADED_BIT] = loaded;
                next_prdata[STAT_INIT_DONE_BIT] = init_done;
            end
            default: next_prdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            PRDATA_O <= 32'h00000000;
            PSLVERR_O <= 1'b0;
        end else if (req.psel && !req.penable) begin
            PRDATA_O <= req.pwrite ? 32'h00000000 : next_prdata;
            PSLVERR_O <= !(reg_hit(IDX_STATION_ADDRESS_HIGH)
                || reg_hit(IDX_STATION_ADDRESS_LOW)
                || reg_hit(IDX_GROUP_HASH_UPPER)
                || reg_hit(IDX_GROUP_HASH_LOWER)
                || reg_hit(IDX_FILTER_CONTROL)
                || reg_hit(IDX_FILTER_STATUS));
        end else if (!req.psel) begin
            PSLVERR_O <= 1'b0;
        end
    end

    // init done is held once seen; host address writes are dropped until then
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            init_done <= 1'b0;
            loaded <= 1'b0;
        end else begin
            if (INIT_DONE_I) begin
                init_done <= 1'b1;
            end
            if (!init_done && ROM_PROGRAMMED_I && rom.valid
                && rom.addr == ROM_LAST_ADDR_BYTE) begin
                loaded <= 1'b1;
            end
        end
    end

    // address writes before init are dropped so the load cannot be torn
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            station_address_high <= RST_STATION_ADDRESS_HIGH;
            station_address_low <= RST_STATION_ADDRESS_LOW;
        end else if (!init_done) begin
            if (ROM_PROGRAMMED_I && rom.valid) begin
                if (rom.addr >= ROM_FIRST_ADDR_BYTE
                    && rom.addr <= ROM_LAST_LOW_BYTE) begin
                    // byte 0x01 is first on the wire, bits 7:0
                    station_address_low[8 * (rom.addr - 4'h1) +: 8]
                        <= rom.data;
                end else if (rom.addr > ROM_LAST_LOW_BYTE
                    && rom.addr <= ROM_LAST_ADDR_BYTE) begin
                    station_address_high[8 * (rom.addr - 4'h5) +: 8]
                        <= rom.data;
                end
            end
        end else if (access && req.pwrite) begin
            if (reg_hit(IDX_STATION_ADDRESS_HIGH)) begin
                station_address_high <= {16'h0000, req.pwdata[15:0]};
            end
            if (reg_hit(IDX_STATION_ADDRESS_LOW)) begin
                station_address_low <= req.pwdata;
            end
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            group_hash_upper <= RST_GROUP_HASH;
            group_hash_lower <= RST_GROUP_HASH;
            accept_every_group_frame <= 1'b0;
        end else if (access && req.pwrite) begin
            if (reg_hit(IDX_GROUP_HASH_UPPER)) begin
                group_hash_upper <= req.pwdata;
            end
            if (reg_hit(IDX_GROUP_HASH_LOWER)) begin
                group_hash_lower <= req.pwdata;
            end
            if (reg_hit(IDX_FILTER_CONTROL)) begin
                accept_every_group_frame <= req.pwdata[CTRL_ACCEPT_ALL_BIT];
            end
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            STATION_ADDRESS_O <= 48'h000000000000;
        end else begin
            // first wire byte (low bits 7:0) becomes the leftmost byte
            STATION_ADDRESS_O <= {station_address_low[7:0],
                station_address_low[15:8], station_address_low[23:16],
                station_address_low[31:24], station_address_high[7:0],
                station_address_high[15:8]};
        end
    end

    // two stages: crc index first, table lookup second
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            stage_valid <= 1'b0;
            stage_group <= 1'b0;
            stage_index <= 6'h00;
        end else begin
            stage_valid <= frm.valid;
            stage_group <= frame_group;
            stage_index <= hash_index;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            FILTER_VALID_O <= 1'b0;
            FILTER_ACCEPT_O <= 1'b0;
        end else begin
            FILTER_VALID_O <= stage_valid;
            if (!stage_valid || !stage_group) begin
                FILTER_ACCEPT_O <= 1'b0;
            end else if (accept_every_group_frame) begin
                FILTER_ACCEPT_O <= 1'b1;
            end else if (stage_index[5]) begin
                FILTER_ACCEPT_O <= group_hash_upper[stage_index[4:0]];
            end else begin
                FILTER_ACCEPT_O <= group_hash_lower[stage_index[4:0]];
            end
        end
    end

    // table taken as it stood in the decision cycle, so a write racing
    // the lookup does not trip the check
    a_hash_select: assert property (
        @(posedge CLOCK_I) disable iff (SYS_RST_I)
        stage_valid && stage_group && !accept_every_group_frame
        |=> FILTER_ACCEPT_O == $past(hash_table[stage_index]))
        else $error("hash table bit not applied");
    a_accept_all: assert property (
        @(posedge CLOCK_I) disable iff (SYS_RST_I)
        stage_valid && stage_group && accept_every_group_frame
        |=> FILTER_ACCEPT_O)
        else $error("accept-all frame rejected");
    a_filter_latency: assert property (
        @(posedge CLOCK_I) disable iff (SYS_RST_I)
        frm.valid |-> ##2 FILTER_VALID_O)
        else $error("filter answer not two cycles after request");
    // read data is latched at setup, so compare with the value seen there
    a_addr_high_read: assert property (
        @(posedge CLOCK_I) disable iff (SYS_RST_I)
        req.psel && !req.penable && !req.pwrite
        && reg_hit(IDX_STATION_ADDRESS_HIGH)
        |=> PRDATA_O == {16'h0000, $past(station_address_high[15:0])})
        else $error("high address read wrong");
    a_addr_low_read: assert property (
        @(posedge CLOCK_I) disable iff (SYS_RST_I)
        req.psel && !req.penable && !req.pwrite
        && reg_hit(IDX_STATION_ADDRESS_LOW)
        |=> PRDATA_O == $past(station_address_low))
        else $error("low address read wrong");
    a_addr_locked: assert property (
        @(posedge CLOCK_I) disable iff (SYS_RST_I)
        !init_done && !rom.valid |=> $stable(station_address_low))
        else $error("address changed before init without loader");
    a_rom_low_byte: assert property (
        @(posedge CLOCK_I) disable iff (SYS_RST_I)
        !init_done && ROM_PROGRAMMED_I && rom.valid
        && rom.addr == ROM_FIRST_ADDR_BYTE
        |=> station_address_low[7:0] == $past(rom.data))
        else $error("rom byte one not in low bits");
    a_rom_high_byte: assert property (
        @(posedge CLOCK_I) disable iff (SYS_RST_I)
        !init_done && ROM_PROGRAMMED_I && rom.valid
        && rom.addr == ROM_LAST_ADDR_BYTE
        |=> station_address_high[15:8] == $past(rom.data))
        else $error("rom byte six not in high bits 15:8");
    a_rom_absent: assert property (
        @(posedge CLOCK_I) disable iff (SYS_RST_I)
        !init_done && !ROM_PROGRAMMED_I |=> $stable(station_address_high))
        else $error("address loaded without programmed rom");

    c_group_accept: cover property (@(posedge CLOCK_I)
        FILTER_VALID_O && FILTER_ACCEPT_O);
    c_group_reject: cover property (@(posedge CLOCK_I)
        stage_valid && stage_group ##1 FILTER_VALID_O && !FILTER_ACCEPT_O);
    c_rom_load: cover property (@(posedge CLOCK_I) loaded && init_done);
    c_hash_write: cover property (@(posedge CLOCK_I)
        access && req.pwrite && reg_hit(IDX_GROUP_HASH_UPPER));
    c_bus_error: cover property (@(posedge CLOCK_I) PREADY_O && PSLVERR_O);
endmodule

// ### test/mac_station_addr_hash_filter_bench.sv
// Purpose: self-checking bench for the station address and hash filter
// Assumes: apb answers in the access cycle, filter answers 2 cycles on
// Notes: expected hash index recomputed here from the crc rules
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    n_fail++; $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); \
    end end
module mac_station_addr_hash_filter_bench;
    import mac_filter_pkg::*;
    logic clk, rst, psel, pen, pwr, prog, start, slow, fv, er;
    logic pready, perr, rv, ridone, v_o, acc_o;
    logic [3:0] ra;
    logic [7:0] rdat;
    logic [11:0] paddr;
    logic [31:0] pwd, prd, rd, hu, hl, seed;
    logic [47:0] dest, sta, img, d;
    int n_fail, samples_checked;
    mac_station_addr_hash_filter dut (.CLOCK_I(clk), .SYS_RST_I(rst),
        .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
        .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(pready),
        .PSLVERR_O(perr), .ROM_PROGRAMMED_I(prog), .ROM_BYTE_VALID_I(rv),
        .ROM_BYTE_ADDR_I(ra), .ROM_BYTE_DATA_I(rdat), .INIT_DONE_I(ridone),
        .FRAME_VALID_I(fv), .FRAME_DEST_I(dest), .FILTER_VALID_O(v_o),
        .FILTER_ACCEPT_O(acc_o), .STATION_ADDRESS_O(sta));
    rom_loader_model loader (.clk_i(clk), .rst_i(rst), .start_i(start),
        .slow_i(slow), .image_i(img), .byte_valid_o(rv), .byte_addr_o(ra),
        .byte_data_o(rdat), .init_done_o(ridone));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    function logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    function logic [47:0] rnd48();
        logic [47:0] c;
        c[47:16] = rnd();
        c[15:0] = 16'(rnd());
        return c;
    endfunction
    // wire order, each byte lsb first, no final invert
    function automatic logic [5:0] hidx(input logic [47:0] dd);
        logic [31:0] c;
        logic fb;
        c = CRC_INIT;
        for (int i = 47; i >= 0; i -= 8) begin
            for (int b = 0; b < 8; b++) begin
                fb = c[31] ^ dd[i - 7 + b];
                c = {c[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h00000000);
            end
        end
        return c[31:26];
    endfunction
    function logic exp_acc(input logic [47:0] dd, input logic all);
        logic [63:0] t;
        t = {hu, hl};
        return dd[40] & (all | t[hidx(dd)]);
    endfunction
    // random group address whose index hits k, to reach the table ends
    function logic [47:0] pick(input logic [5:0] k);
        logic [47:0] c;
        c = 48'h0;
        for (int i = 0; i < 4000; i++) begin
            c = rnd48();
            c[40] = 1'b1;
            if (hidx(c) == k) break;
        end
        return c;
    endfunction
    task close_out;
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task apb(input logic w, input logic [3:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= {6'h00, idx, 2'h0};
        pwd <= wd;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            n_fail++;
            close_out();
        end
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task rchk(input logic [3:0] idx, input logic [31:0] e);
        apb(1'b0, idx, 32'h00000000);
        // a mapped register must answer without an error flag
        `CHK({er, rd}, {1'b0, e})
    endtask
    task frame(input logic [47:0] dd, input logic e);
        @(posedge clk);
        fv <= 1'b1;
        dest <= dd;
        @(posedge clk);
        fv <= 1'b0;
        dest <= ~dd;
        @(posedge clk);
        #1;
        `CHK(v_o, 1'b1)
        `CHK(acc_o, e)
    endtask
    task do_reset;
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
    endtask
    task wait_init;
        int n;
        for (n = 0; n < 64 && ridone !== 1'b1; n++) @(posedge clk);
        if (n >= 64) begin
            n_fail++;
            close_out();
        end
    endtask
    initial begin
        {psel, pen, pwr, fv, start, prog} = 6'h00;
        rst = 1'b1;
        slow = 1'b1;
        paddr = 12'h000;
        pwd = 32'h00000000;
        dest = 48'h0;
        n_fail = 0;
        samples_checked = 0;
        seed = 32'hD42F;
        img = rnd48();
        do_reset();
        rchk(IDX_GROUP_HASH_UPPER, 32'h00000000);
        rchk(IDX_GROUP_HASH_LOWER, 32'h00000000);
        rchk(IDX_FILTER_STATUS, 32'h00000000);
        apb(1'b0, 4'hF, 32'h00000000);
        `CHK({er, rd}, {1'b1, 32'h00000000})
        // unprogrammed rom: bytes arrive but must be ignored
        start <= 1'b1;
        wait_init();
        // init finished but nothing loaded
        rchk(IDX_FILTER_STATUS, 32'h00000001 << STAT_INIT_DONE_BIT);
        rchk(IDX_STATION_ADDRESS_HIGH, 32'h0000FFFF);
        rchk(IDX_STATION_ADDRESS_LOW, 32'h0FFFFFFF);
        start <= 1'b0;
        do_reset();
        prog <= 1'b1;
        slow <= 1'b0;
        apb(1'b1, IDX_STATION_ADDRESS_LOW, 32'h00000000);
        rchk(IDX_STATION_ADDRESS_LOW, 32'h0FFFFFFF);
        start <= 1'b1;
        wait_init();
        rchk(IDX_STATION_ADDRESS_HIGH, {16'h0, img[7:0], img[15:8]});
        rchk(IDX_STATION_ADDRESS_LOW, {img[23:16], img[31:24],
            img[39:32], img[47:40]});
        `CHK(sta, img)
        rchk(IDX_FILTER_STATUS, (32'h00000001 << STAT_INIT_DONE_BIT)
            | (32'h00000001 << STAT_LOADED_BIT));
        hu = rnd();
        hl = rnd();
        apb(1'b1, IDX_STATION_ADDRESS_HIGH, hu);
        apb(1'b1, IDX_STATION_ADDRESS_LOW, hl);
        rchk(IDX_STATION_ADDRESS_HIGH, {16'h0, hu[15:0]});
        rchk(IDX_STATION_ADDRESS_LOW, hl);
        `CHK(sta, {hl[7:0], hl[15:8], hl[23:16], hl[31:24], hu[7:0], hu[15:8]})
        for (int t = 0; t < 6; t++) begin
            hu = (t == 1) ? 32'h80000000 : ((t == 0) ? 32'h0 : rnd());
            hl = (t == 0) ? 32'h00000001 : ((t == 1) ? 32'h0 : rnd());
            apb(1'b1, IDX_GROUP_HASH_UPPER, hu);
            apb(1'b1, IDX_GROUP_HASH_LOWER, hl);
            rchk(IDX_GROUP_HASH_UPPER, hu);
            rchk(IDX_GROUP_HASH_LOWER, hl);
            for (int a = 0; a < 2; a++) begin
                apb(1'b1, IDX_FILTER_CONTROL, {31'h0, a[0]});
                rchk(IDX_FILTER_CONTROL,
                    {31'h0, a[0]} << CTRL_ACCEPT_ALL_BIT);
                d = pick(6'h00);
                frame(d, exp_acc(d, a[0]));
                d = pick(6'h3F);
                frame(d, exp_acc(d, a[0]));
                repeat (8) begin
                    d = rnd48();
                    frame(d, exp_acc(d, a[0]));
                end
            end
        end
        close_out();
    end
endmodule

// ### test/rom_loader_model.sv
// Purpose: power-on loader that feeds address bytes 1..6 from an image
// Assumes: image_i[47:40] is byte 1, the first byte on the wire
// Notes: slow_i leaves a gap after each byte; idle lines toggle
`timescale 1ns/1ps
module rom_loader_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic start_i,
    input wire logic slow_i,
    input wire logic [47:0] image_i,
    // byte stream
    output logic byte_valid_o,
    output logic [3:0] byte_addr_o,
    output logic [7:0] byte_data_o,
    output logic init_done_o
);
    logic [3:0] next_addr;
    logic gap;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            next_addr <= 4'h1;
            gap <= 1'b0;
            byte_valid_o <= 1'b0;
            byte_addr_o <= 4'h0;
            byte_data_o <= 8'h00;
            init_done_o <= 1'b0;
        end else if (start_i && !init_done_o && !gap && next_addr < 4'h7) begin
            // bytes go out in ascending address order
            byte_valid_o <= 1'b1;
            byte_addr_o <= next_addr;
            byte_data_o <= image_i[8 * (6 - int'(next_addr)) +: 8];
            next_addr <= next_addr + 4'h1;
            gap <= slow_i;
        end else begin
            // stale lines must not look like a held byte
            byte_valid_o <= 1'b0;
            byte_addr_o <= ~byte_addr_o;
            byte_data_o <= ~byte_data_o;
            gap <= 1'b0;
            if (start_i && next_addr == 4'h7) begin
                init_done_o <= 1'b1;
            end
        end
    end
endmodule
